// ==== common/node_cfg_pkg.sv ====
package node_cfg_pkg;

  // ----------------------------------------------------------------
  // register numbers
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_SWITCH_CONFIGURATION = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] REG_SYNTHESIZER_SETTINGS = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
  localparam logic [7:0] REG_TEST_PORT_DEVICE_ID = 8'h09;
  localparam logic [7:0] REG_USER_CODE = 8'h0A;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_LOW = 8'h0C;
  localparam logic [7:0] REG_ROUTE_DIRECTIONS_HIGH = 8'h0D;
  localparam logic [7:0] REG_RESERVED_A = 8'h10;
  localparam logic [7:0] REG_RESERVED_B = 8'h11;
  localparam logic [7:0] REG_DEBUG_EVENT_SOURCE = 8'h1F;

  // ----------------------------------------------------------------
  // field positions and widths
  // ----------------------------------------------------------------
  localparam int SWCFG_LOCK_ALL_BIT = 31;
  localparam int SWCFG_LOCK_SYNTH_BIT = 8;
  localparam int SWCFG_HEADER_BIT = 0;
  localparam int SYN_NO_RESET_BIT = 31;
  localparam int SYN_NO_WAIT_BIT = 30;
  localparam int SYN_BYPASS_BIT = 29;
  localparam int SYN_BOOT_TP_BIT = 28;
  localparam int SYN_OD_LSB = 23;
  localparam int SYN_OD_W = 3;
  localparam int SYN_F_LSB = 8;
  localparam int SYN_F_W = 13;
  localparam int SYN_R_LSB = 0;
  localparam int SYN_R_W = 7;
  localparam int NODE_ID_W = 16;
  localparam int DIV_W = 16;
  localparam int DIR_W = 4;
  localparam int USERCODE_LSB = 18;
  localparam int USERCODE_W = 14;
  localparam int REVISION_W = 18;
  localparam int RSVD_W = 2;
  localparam int DBG_TILE0_BIT = 0;
  localparam int DBG_TILE1_BIT = 1;
  localparam int DBG_SPARE_BIT = 4;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SWCFG_RESET = 32'h0000_0000;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;
  localparam logic [31:0] SYNTH_RESET = 32'h0000_0000;
  localparam logic [15:0] SWDIV_RESET = 16'h0000;
  localparam logic [15:0] REFDIV_RESET = 16'h0003;
  localparam logic [31:0] DIRS_RESET = 32'h0000_0000;
  localparam logic [1:0] RSVD_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int TILE_RESET_NS = 100;
  localparam int TILE_RESET_CYCLES = (TILE_RESET_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int LOCK_SETTLE_NS = 1000;
  localparam int LOCK_SETTLE_CYCLES = (LOCK_SETTLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RELOCK_TIMEOUT_US = 100;
  localparam int RELOCK_TIMEOUT_CYCLES = (RELOCK_TIMEOUT_US * 1000000) / CLK_PERIOD_PS;
  localparam int SEQ_CNT_W = 16;

  // ----------------------------------------------------------------
  // synthesizer update sequence
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_WAIT_LOCK = 2'b01,
    SEQ_TILE_RESET = 2'b10
  } seq_state_t;

endpackage

// ==== design/route_dir_select.sv ====
`timescale 1ns/1ps

// picks the direction of the highest mismatching identifier bit
module route_dir_select #(
  parameter int ID_W = 16,
  parameter int DIR_W = 4,
  parameter int DIM_W = $clog2(ID_W)
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic req_valid,
  input wire logic [ID_W-1:0] req_dest,
  input wire logic [ID_W-1:0] node_id,
  input wire logic [ID_W*DIR_W-1:0] dir_table,
  output logic resp_valid,
  output logic resp_local,
  output logic [DIM_W-1:0] resp_dim,
  output logic [DIR_W-1:0] resp_dir
);

  logic [ID_W-1:0] diff;
  logic found;
  logic [DIM_W-1:0] dim;

  // ----------------------------------------------------------------
  // most significant mismatch search
  // ----------------------------------------------------------------
  always_comb begin
    diff = req_dest ^ node_id;
    found = 1'b0;
    dim = '0;
    for (int i = 0; i < ID_W; i++) begin
      if (diff[i]) begin
        found = 1'b1;
        dim = DIM_W'(i);
      end
    end
  end

  // registered answer one cycle after the request
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resp_valid <= 1'b0;
      resp_local <= 1'b0;
      resp_dim <= '0;
      resp_dir <= '0;
    end else begin
      resp_valid <= req_valid;
      if (req_valid) begin
        resp_local <= ~found;
        resp_dim <= dim;
        resp_dir <= dir_table[dim*DIR_W +: DIR_W];
      end
    end
  end

endmodule // route_dir_select

// ==== design/switch_node_config_regs.sv ====
`timescale 1ns/1ps

// Operation
// - top switch-config bit blocks control register writes
// - switch-config bit 8 blocks synthesizer writes
// - switch-config bit 0 picks header length
// - sixteen-bit node identity, upper bits reserved
// - synthesizer write resets tile unless suppressed
// - synthesizer bit 31 applies without reset
// - synthesizer bit 30 skips relock wait
// - synthesizer bit 29 selects bypass
// - synthesizer bit 28 boots from test port
// - synthesizer bits 25:23 output divider
// - synthesizer bits 20:8 feedback multiplier
// - synthesizer bits 6:0 input divider
// - sixteen-bit switch clock divider, reset zero
// - sixteen-bit reference clock divider, reset three
// - user code reads otp code and revision
// - low direction table covers dimensions 0-7
// - high direction table covers dimensions 8-15
// - route by highest mismatching identifier bit
// - eight nibbles per table, lowest dimension first
// - debug source shows which tile raised event
module switch_node_config_regs #(
  parameter logic [31:0] DEVICE_ID_CODE = 32'h1234_5671, // arbitrary value
  parameter logic [17:0] REVISION_CODE = 18'h00001, // arbitrary value
  parameter int RELOCK_TIMEOUT = node_cfg_pkg::RELOCK_TIMEOUT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_ack,
  output logic cfg_err,
  output logic [31:0] cfg_rdata,
  input wire logic [13:0] otp_user_code,
  input wire logic synth_lock_pin,
  input wire logic tile0_debug_event,
  input wire logic tile1_debug_event,
  input wire logic route_req_valid,
  input wire logic [15:0] route_req_dest,
  output logic route_resp_valid,
  output logic route_resp_local,
  output logic [3:0] route_resp_dim,
  output logic [3:0] route_resp_dir,
  output logic one_byte_header,
  output logic [15:0] node_id,
  output logic synth_bypass,
  output logic boot_from_test_port,
  output logic [2:0] synth_output_divider,
  output logic [12:0] synth_feedback_mult,
  output logic [6:0] synth_input_divider,
  output logic [15:0] switch_clock_divider,
  output logic [15:0] reference_clock_divider,
  output logic synth_relock_busy,
  output logic tile_reset
);

  localparam logic [15:0] TILE_RESET_LEN = 16'(node_cfg_pkg::TILE_RESET_CYCLES);
  localparam logic [15:0] LOCK_SETTLE_LEN = 16'(node_cfg_pkg::LOCK_SETTLE_CYCLES);
  localparam logic [15:0] RELOCK_LIMIT = 16'(RELOCK_TIMEOUT);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  logic [31:0] swcfg_q;
  logic [15:0] node_id_q;
  logic [31:0] synth_q;
  logic [15:0] swdiv_q;
  logic [15:0] refdiv_q;
  logic [31:0] dirs_low_q;
  logic [31:0] dirs_high_q;
  logic [1:0] rsvd_a_q;
  logic [1:0] rsvd_b_q;
  logic [1:0] dbg_src_q;
  logic dbg_spare_q;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic wr;
  logic rd;
  logic lock_all;
  logic lock_synth;
  logic seq_busy;
  logic mapped;
  logic read_only;
  logic blocked;
  logic wr_ok;
  logic wr_synth;
  logic [31:0] rdata_d;

  assign wr = cfg_valid & cfg_write;
  assign rd = cfg_valid & ~cfg_write;
  assign lock_all = swcfg_q[node_cfg_pkg::SWCFG_LOCK_ALL_BIT];
  assign lock_synth = swcfg_q[node_cfg_pkg::SWCFG_LOCK_SYNTH_BIT];

  // which numbers answer, and which refuse writes
  always_comb begin
    mapped = 1'b1;
    read_only = 1'b0;
    case (cfg_addr)
      node_cfg_pkg::REG_SWITCH_CONFIGURATION: mapped = 1'b1;
      node_cfg_pkg::REG_NODE_IDENTIFIER: mapped = 1'b1;
      node_cfg_pkg::REG_SYNTHESIZER_SETTINGS: mapped = 1'b1;
      node_cfg_pkg::REG_SWITCH_CLOCK_DIVIDER: mapped = 1'b1;
      node_cfg_pkg::REG_REFERENCE_CLOCK_DIVIDER: mapped = 1'b1;
      node_cfg_pkg::REG_TEST_PORT_DEVICE_ID: read_only = 1'b1;
      node_cfg_pkg::REG_USER_CODE: read_only = 1'b1;
      node_cfg_pkg::REG_ROUTE_DIRECTIONS_LOW: mapped = 1'b1;
      node_cfg_pkg::REG_ROUTE_DIRECTIONS_HIGH: mapped = 1'b1;
      node_cfg_pkg::REG_RESERVED_A: mapped = 1'b1;
      node_cfg_pkg::REG_RESERVED_B: mapped = 1'b1;
      node_cfg_pkg::REG_DEBUG_EVENT_SOURCE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // protection: lock_all guards every register but its own
  always_comb begin
    blocked = 1'b0;
    if (lock_all && cfg_addr != node_cfg_pkg::REG_SWITCH_CONFIGURATION) begin
      blocked = 1'b1;
    end
    if (cfg_addr == node_cfg_pkg::REG_SYNTHESIZER_SETTINGS && (lock_synth || seq_busy)) begin
      blocked = 1'b1;
    end
  end

  assign wr_ok = wr & mapped & ~read_only & ~blocked;
  assign wr_synth = wr_ok & (cfg_addr == node_cfg_pkg::REG_SYNTHESIZER_SETTINGS);

  // ----------------------------------------------------------------
  // answer to the configuration port
  // ----------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    case (cfg_addr)
      node_cfg_pkg::REG_SWITCH_CONFIGURATION: begin
        rdata_d[node_cfg_pkg::SWCFG_LOCK_ALL_BIT] = lock_all;
        rdata_d[node_cfg_pkg::SWCFG_LOCK_SYNTH_BIT] = lock_synth;
        rdata_d[node_cfg_pkg::SWCFG_HEADER_BIT] = swcfg_q[node_cfg_pkg::SWCFG_HEADER_BIT];
      end
      node_cfg_pkg::REG_NODE_IDENTIFIER: rdata_d[15:0] = node_id_q;
      node_cfg_pkg::REG_SYNTHESIZER_SETTINGS: rdata_d = synth_q;
      node_cfg_pkg::REG_SWITCH_CLOCK_DIVIDER: rdata_d[15:0] = swdiv_q;
      node_cfg_pkg::REG_REFERENCE_CLOCK_DIVIDER: rdata_d[15:0] = refdiv_q;
      node_cfg_pkg::REG_TEST_PORT_DEVICE_ID: rdata_d = DEVICE_ID_CODE;
      node_cfg_pkg::REG_USER_CODE: rdata_d = {otp_user_code, REVISION_CODE};
      node_cfg_pkg::REG_ROUTE_DIRECTIONS_LOW: rdata_d = dirs_low_q;
      node_cfg_pkg::REG_ROUTE_DIRECTIONS_HIGH: rdata_d = dirs_high_q;
      node_cfg_pkg::REG_RESERVED_A: rdata_d[1:0] = rsvd_a_q;
      node_cfg_pkg::REG_RESERVED_B: rdata_d[1:0] = rsvd_b_q;
      node_cfg_pkg::REG_DEBUG_EVENT_SOURCE: begin
        rdata_d[1:0] = dbg_src_q;
        rdata_d[node_cfg_pkg::DBG_SPARE_BIT] = dbg_spare_q;
      end
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // one answer per request, the next cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_ack <= 1'b0;
      cfg_err <= 1'b0;
      cfg_rdata <= 32'h0000_0000;
    end else begin
      cfg_ack <= cfg_valid;
      cfg_err <= cfg_valid & (~mapped & ~read_only | wr & (read_only | blocked));
      cfg_rdata <= rd ? rdata_d : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // switch configuration and node identity
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      swcfg_q <= node_cfg_pkg::SWCFG_RESET;
      node_id_q <= node_cfg_pkg::NODE_ID_RESET;
    end else if (wr_ok) begin
      if (cfg_addr == node_cfg_pkg::REG_SWITCH_CONFIGURATION) begin
        swcfg_q <= 32'h0000_0000;
        swcfg_q[node_cfg_pkg::SWCFG_LOCK_ALL_BIT] <= cfg_wdata[node_cfg_pkg::SWCFG_LOCK_ALL_BIT];
        swcfg_q[node_cfg_pkg::SWCFG_LOCK_SYNTH_BIT] <= cfg_wdata[node_cfg_pkg::SWCFG_LOCK_SYNTH_BIT];
        swcfg_q[node_cfg_pkg::SWCFG_HEADER_BIT] <= cfg_wdata[node_cfg_pkg::SWCFG_HEADER_BIT];
      end
      if (cfg_addr == node_cfg_pkg::REG_NODE_IDENTIFIER) begin
        node_id_q <= cfg_wdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // clock dividers, direction tables, spare bits
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      swdiv_q <= node_cfg_pkg::SWDIV_RESET;
      refdiv_q <= node_cfg_pkg::REFDIV_RESET;
      dirs_low_q <= node_cfg_pkg::DIRS_RESET;
      dirs_high_q <= node_cfg_pkg::DIRS_RESET;
      rsvd_a_q <= node_cfg_pkg::RSVD_RESET;
      rsvd_b_q <= node_cfg_pkg::RSVD_RESET;
    end else if (wr_ok) begin
      case (cfg_addr)
        node_cfg_pkg::REG_SWITCH_CLOCK_DIVIDER: swdiv_q <= cfg_wdata[15:0];
        node_cfg_pkg::REG_REFERENCE_CLOCK_DIVIDER: refdiv_q <= cfg_wdata[15:0];
        node_cfg_pkg::REG_ROUTE_DIRECTIONS_LOW: dirs_low_q <= cfg_wdata;
        node_cfg_pkg::REG_ROUTE_DIRECTIONS_HIGH: dirs_high_q <= cfg_wdata;
        node_cfg_pkg::REG_RESERVED_A: rsvd_a_q <= cfg_wdata[1:0];
        node_cfg_pkg::REG_RESERVED_B: rsvd_b_q <= cfg_wdata[1:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // debug event source
  // ----------------------------------------------------------------
  // a new event wins over a clearing write in the same cycle
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      dbg_src_q <= 2'h0;
      dbg_spare_q <= 1'b0;
    end else begin
      if (tile0_debug_event || tile1_debug_event) begin
        dbg_src_q <= {tile1_debug_event, tile0_debug_event};
      end else if (wr_ok && cfg_addr == node_cfg_pkg::REG_DEBUG_EVENT_SOURCE) begin
        dbg_src_q <= cfg_wdata[1:0];
      end
      if (wr_ok && cfg_addr == node_cfg_pkg::REG_DEBUG_EVENT_SOURCE) begin
        dbg_spare_q <= cfg_wdata[node_cfg_pkg::DBG_SPARE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // synthesizer settings
  // ----------------------------------------------------------------
  // reserved bits are dropped on store
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      synth_q <= node_cfg_pkg::SYNTH_RESET;
    end else if (wr_synth) begin
      synth_q <= 32'h0000_0000;
      synth_q[node_cfg_pkg::SYN_NO_RESET_BIT] <= cfg_wdata[node_cfg_pkg::SYN_NO_RESET_BIT];
      synth_q[node_cfg_pkg::SYN_NO_WAIT_BIT] <= cfg_wdata[node_cfg_pkg::SYN_NO_WAIT_BIT];
      synth_q[node_cfg_pkg::SYN_BYPASS_BIT] <= cfg_wdata[node_cfg_pkg::SYN_BYPASS_BIT];
      synth_q[node_cfg_pkg::SYN_BOOT_TP_BIT] <= cfg_wdata[node_cfg_pkg::SYN_BOOT_TP_BIT];
      synth_q[node_cfg_pkg::SYN_OD_LSB +: node_cfg_pkg::SYN_OD_W] <=
        cfg_wdata[node_cfg_pkg::SYN_OD_LSB +: node_cfg_pkg::SYN_OD_W];
      synth_q[node_cfg_pkg::SYN_F_LSB +: node_cfg_pkg::SYN_F_W] <=
        cfg_wdata[node_cfg_pkg::SYN_F_LSB +: node_cfg_pkg::SYN_F_W];
      synth_q[node_cfg_pkg::SYN_R_LSB +: node_cfg_pkg::SYN_R_W] <=
        cfg_wdata[node_cfg_pkg::SYN_R_LSB +: node_cfg_pkg::SYN_R_W];
    end
  end

  // ----------------------------------------------------------------
  // lock input synchroniser
  // ----------------------------------------------------------------
  logic lock_s1_q;
  logic lock_s2_q;
  logic lock_s3_q;
  logic lock_q;

  // three stages; level follows once stages two and three agree
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lock_s1_q <= 1'b0;
      lock_s2_q <= 1'b0;
      lock_s3_q <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      lock_s1_q <= synth_lock_pin;
      lock_s2_q <= lock_s1_q;
      lock_s3_q <= lock_s2_q;
      if (lock_s2_q == lock_s3_q) begin
        lock_q <= lock_s3_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // update sequence: relock wait, then tile reset
  // ----------------------------------------------------------------
  node_cfg_pkg::seq_state_t seq_q;
  logic [15:0] seq_cnt_q;
  logic no_reset_q;

  assign seq_busy = (seq_q != node_cfg_pkg::SEQ_IDLE);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      seq_q <= node_cfg_pkg::SEQ_IDLE;
      seq_cnt_q <= 16'h0000;
      no_reset_q <= 1'b0;
    end else begin
      case (seq_q)
        node_cfg_pkg::SEQ_IDLE: begin
          seq_cnt_q <= 16'h0000;
          if (wr_synth) begin
            no_reset_q <= cfg_wdata[node_cfg_pkg::SYN_NO_RESET_BIT];
            if (!cfg_wdata[node_cfg_pkg::SYN_NO_WAIT_BIT]) begin
              seq_q <= node_cfg_pkg::SEQ_WAIT_LOCK;
            end else if (!cfg_wdata[node_cfg_pkg::SYN_NO_RESET_BIT]) begin
              seq_q <= node_cfg_pkg::SEQ_TILE_RESET;
            end
          end
        end
        node_cfg_pkg::SEQ_WAIT_LOCK: begin
          seq_cnt_q <= seq_cnt_q + 16'h0001;
          if ((seq_cnt_q >= LOCK_SETTLE_LEN - 16'h0001 && lock_q) ||
              seq_cnt_q >= RELOCK_LIMIT - 16'h0001) begin
            seq_cnt_q <= 16'h0000;
            seq_q <= no_reset_q ? node_cfg_pkg::SEQ_IDLE : node_cfg_pkg::SEQ_TILE_RESET;
          end
        end
        node_cfg_pkg::SEQ_TILE_RESET: begin
          seq_cnt_q <= seq_cnt_q + 16'h0001;
          if (seq_cnt_q >= TILE_RESET_LEN - 16'h0001) begin
            seq_cnt_q <= 16'h0000;
            seq_q <= node_cfg_pkg::SEQ_IDLE;
          end
        end
        default: seq_q <= node_cfg_pkg::SEQ_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // route lookup
  // ----------------------------------------------------------------
  route_dir_select #(
    .ID_W(node_cfg_pkg::NODE_ID_W),
    .DIR_W(node_cfg_pkg::DIR_W)
  ) u_route (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .req_valid(route_req_valid),
    .req_dest(route_req_dest),
    .node_id(node_id_q),
    .dir_table({dirs_high_q, dirs_low_q}),
    .resp_valid(route_resp_valid),
    .resp_local(route_resp_local),
    .resp_dim(route_resp_dim),
    .resp_dir(route_resp_dir)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // configuration outputs straight from the registers
  assign one_byte_header = swcfg_q[node_cfg_pkg::SWCFG_HEADER_BIT];
  assign node_id = node_id_q;
  assign synth_bypass = synth_q[node_cfg_pkg::SYN_BYPASS_BIT];
  assign boot_from_test_port = synth_q[node_cfg_pkg::SYN_BOOT_TP_BIT];
  assign synth_output_divider = synth_q[node_cfg_pkg::SYN_OD_LSB +: node_cfg_pkg::SYN_OD_W];
  assign synth_feedback_mult = synth_q[node_cfg_pkg::SYN_F_LSB +: node_cfg_pkg::SYN_F_W];
  assign synth_input_divider = synth_q[node_cfg_pkg::SYN_R_LSB +: node_cfg_pkg::SYN_R_W];
  assign switch_clock_divider = swdiv_q;
  assign reference_clock_divider = refdiv_q;
  assign synth_relock_busy = (seq_q == node_cfg_pkg::SEQ_WAIT_LOCK);
  assign tile_reset = (seq_q == node_cfg_pkg::SEQ_TILE_RESET);

endmodule // switch_node_config_regs

// ==== testbench/switch_node_config_regs_monitor.sv ====
`timescale 1ns/1ps

module switch_node_config_regs_monitor (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic cfg_valid,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_addr,
  input wire logic [31:0] cfg_wdata,
  input wire logic cfg_ack,
  input wire logic cfg_err,
  input wire logic route_req_valid,
  input wire logic route_resp_valid,
  input wire logic one_byte_header,
  input wire logic [15:0] node_id,
  input wire logic [2:0] synth_output_divider,
  input wire logic synth_relock_busy,
  input wire logic tile_reset
);
  logic lock_all_q;
  logic lock_syn_q;
  logic w04;
  logic w05;
  logic w06;
  logic w06_ok;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // decoded writes
  assign w04 = cfg_valid && cfg_write && cfg_addr == node_cfg_pkg::REG_SWITCH_CONFIGURATION;
  assign w05 = cfg_valid && cfg_write && cfg_addr == node_cfg_pkg::REG_NODE_IDENTIFIER;
  assign w06 = cfg_valid && cfg_write && cfg_addr == node_cfg_pkg::REG_SYNTHESIZER_SETTINGS;
  assign w06_ok = w06 && !lock_all_q && !lock_syn_q && !synth_relock_busy && !tile_reset;
  // mirror of the protection bits
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      lock_all_q <= 1'h0;
      lock_syn_q <= 1'h0;
    end else if (w04) begin
      lock_all_q <= cfg_wdata[31];
      lock_syn_q <= cfg_wdata[8];
    end
  end
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  sequence s_rst_held; tile_reset [*8]; endsequence
  sequence s_no_rst; !tile_reset [*8]; endsequence
  sequence s_busy; synth_relock_busy [*8]; endsequence
  property p_ack; cfg_valid |=> cfg_ack; endproperty
  property p_lock_all; w05 && lock_all_q |=> cfg_err && $stable(node_id); endproperty
  property p_node_id; w05 && !lock_all_q |=> !cfg_err && node_id == $past(cfg_wdata[15:0]);
  endproperty
  property p_hdr; w04 |=> one_byte_header == $past(cfg_wdata[0]); endproperty
  property p_lock_syn; w06 && lock_syn_q |=> cfg_err && $stable(synth_output_divider);
  endproperty
  property p_od; w06_ok |=> synth_output_divider == $past(cfg_wdata[25:23]); endproperty
  property p_rst; w06_ok && cfg_wdata[31:30] == 2'h1 |=> s_rst_held; endproperty
  property p_no_rst; w06_ok && cfg_wdata[31:30] == 2'h3 |=> s_no_rst; endproperty
  property p_relock; w06_ok && !cfg_wdata[30] |=> s_busy; endproperty
  property p_route; route_req_valid |=> route_resp_valid; endproperty
  a_ack: assert property (p_ack) else $error("request not acknowledged");
  a_lock_all: assert property (p_lock_all) else $error("locked write took");
  a_node_id: assert property (p_node_id) else $error("node id not stored");
  a_hdr: assert property (p_hdr) else $error("header mode wrong");
  a_lock_syn: assert property (p_lock_syn) else $error("synth write took");
  a_od: assert property (p_od) else $error("output divider wrong");
  a_rst: assert property (p_rst) else $error("tile reset missing");
  a_no_rst: assert property (p_no_rst) else $error("tile reset unwanted");
  a_relock: assert property (p_relock) else $error("relock wait missing");
  a_route: assert property (p_route) else $error("route answer missing");
endmodule // switch_node_config_regs_monitor

bind switch_node_config_regs switch_node_config_regs_monitor i_switch_node_config_regs_monitor (
  .clk_sys, .sys_rst, .cfg_valid, .cfg_write, .cfg_addr, .cfg_wdata, .cfg_ack, .cfg_err,
  .route_req_valid, .route_resp_valid, .one_byte_header, .node_id, .synth_output_divider,
  .synth_relock_busy, .tile_reset);

// ==== testbench/switch_node_config_regs_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value %s exp %h got %h", n, (e), (g)); end end

module switch_node_config_regs_tb;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic cfg_valid = 1'h0;
  logic cfg_write = 1'h0;
  logic [7:0] cfg_addr = 8'h00;
  logic [31:0] cfg_wdata = 32'h0;
  logic ev0 = 1'h0;
  logic ev1 = 1'h0;
  logic lock = 1'h1;
  logic rq = 1'h0;
  logic [15:0] dest = 16'h0;
  logic cfg_ack, cfg_err, rv, rl, hdr, byp, boot, busy, trst;
  logic [31:0] cfg_rdata;
  logic [3:0] dim, dir;
  logic [15:0] nid, swd, rfd;
  logic [2:0] od;
  logic [12:0] fb;
  logic [6:0] idv;
  int mismatches = 0;
  int checks = 0;
  int cyc = 0;
  switch_node_config_regs #(.REVISION_CODE(18'h0ABCD), .RELOCK_TIMEOUT(300))
    i_switch_node_config_regs (.clk_sys, .sys_rst, .cfg_valid, .cfg_write, .cfg_addr,
    .cfg_wdata, .cfg_ack, .cfg_err, .cfg_rdata, .otp_user_code(14'h2A5A), .synth_lock_pin(lock),
    .tile0_debug_event(ev0), .tile1_debug_event(ev1), .route_req_valid(rq),
    .route_req_dest(dest), .route_resp_valid(rv), .route_resp_local(rl), .route_resp_dim(dim),
    .route_resp_dir(dir), .one_byte_header(hdr), .node_id(nid), .synth_bypass(byp),
    .boot_from_test_port(boot), .synth_output_divider(od), .synth_feedback_mult(fb),
    .synth_input_divider(idv), .switch_clock_divider(swd), .reference_clock_divider(rfd),
    .synth_relock_busy(busy), .tile_reset(trst));
  // --------------------------------------------------------------
  // clock, timeout and bus tasks
  // --------------------------------------------------------------
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      results();
    end
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e,
                     input logic [31:0] r);
    @(negedge clk_sys);
    cfg_valid = 1'h1;
    cfg_write = w;
    cfg_addr = a;
    cfg_wdata = d;
    @(negedge clk_sys);
    cfg_valid = 1'h0;
    `CHK("ack", 1'h1, cfg_ack)
    `CHK("err", e, cfg_err)
    if (!w) `CHK("rdata", r, cfg_rdata)
  endtask
  task automatic rst_len();
    int n;
    n = 0;
    while (trst === 1'h1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK("tile reset length", node_cfg_pkg::TILE_RESET_CYCLES, n)
  endtask
  task automatic t_reset();
    acc(0, 8'h04, 32'h0, 0, 32'h0);
    acc(0, 8'h07, 32'h0, 0, 32'h0);
    acc(0, 8'h08, 32'h0, 0, 32'h3);
    acc(0, 8'h0D, 32'h0, 0, 32'h0);
    `CHK("dividers", 32'h0000_0003, {swd, rfd})
  endtask
  task automatic t_protect();
    acc(1, 8'h04, 32'hFFFF_FFFF, 0, 32'h0);
    acc(0, 8'h04, 32'h0, 0, 32'h8000_0101);
    `CHK("header", 1'h1, hdr)
    acc(1, 8'h05, 32'h0000_00AA, 1, 32'h0);
    `CHK("node id", 16'h0, nid)
    acc(1, 8'h04, 32'h0000_0100, 0, 32'h0);
    acc(1, 8'h06, 32'h0, 1, 32'h0);
    acc(1, 8'h04, 32'h0, 0, 32'h0);
  endtask
  task automatic t_route();
    acc(1, 8'h05, 32'hFFFF_A5C3, 0, 32'h0);
    acc(0, 8'h05, 32'h0, 0, 32'h0000_A5C3);
    acc(1, 8'h0C, 32'h7654_3210, 0, 32'h0);
    acc(1, 8'h0D, 32'hFEDC_BA98, 0, 32'h0);
    for (int d = 0; d < 17; d++) begin
      @(negedge clk_sys);
      rq = 1'h1;
      dest = 16'hA5C3 ^ ((16'h1 << d) | 16'(d > 0 && d < 16));
      @(negedge clk_sys);
      rq = 1'h0;
      `CHK("local", 1'(d == 16), rl)
      if (d < 16) `CHK("dim dir", {4'(d), 4'(d)}, {dim, dir})
    end
  endtask
  task automatic t_synth();
    int n;
    acc(1, 8'h06, 32'hFFFF_FFFF, 0, 32'h0);
    acc(0, 8'h06, 32'h0, 0, 32'hF39F_FF7F);
    `CHK("synth", {5'h1F, 13'h1FFF, 8'hFE}, {byp, boot, od, fb, idv, trst})
    acc(1, 8'h06, 32'h4000_0000, 0, 32'h0);
    `CHK("tile reset", 1'h1, trst)
    rst_len();
    acc(1, 8'h06, 32'h0, 0, 32'h0);
    `CHK("busy", 1'h1, busy)
    acc(1, 8'h06, 32'h0, 1, 32'h0);
    for (int m = 0; m < 1000 && busy === 1'h1; m++) @(negedge clk_sys);
    `CHK("reset after relock", 1'h1, trst)
    rst_len();
    lock = 1'h0;
    acc(1, 8'h06, 32'h8000_0000, 0, 32'h0);
    for (n = 0; n < 1000 && busy === 1'h1; n++) @(negedge clk_sys);
    `CHK("relock timeout", 300, n)
    `CHK("no tile reset", 1'h0, trst)
  endtask
  task automatic t_misc();
    acc(1, 8'h09, 32'h1, 1, 32'h0);
    acc(0, 8'h0A, 32'h0, 0, {14'h2A5A, 18'h0ABCD});
    acc(0, 8'h03, 32'h0, 1, 32'h0);
    @(negedge clk_sys);
    ev1 = 1'h1;
    @(negedge clk_sys);
    ev1 = 1'h0;
    acc(0, 8'h1F, 32'h0, 0, 32'h2);
    acc(1, 8'h1F, 32'h0, 0, 32'h0);
    acc(0, 8'h1F, 32'h0, 0, 32'h0);
    @(negedge clk_sys);
    ev0 = 1'h1;
    @(negedge clk_sys);
    ev0 = 1'h0;
    acc(0, 8'h1F, 32'h0, 0, 32'h1);
  endtask
  task automatic results();
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(negedge clk_sys);
    sys_rst = 1'h0;
    t_reset();
    t_protect();
    t_route();
    t_synth();
    t_misc();
    results();
  end
endmodule // switch_node_config_regs_tb
